/* src/periph_regs.sv */
// Peripheral register bank with shadow set/clear registers, masked interrupt source and two transfer channels
`timescale 1ns/1ps
module periph_regs
  import periph_pkg::*;
#(
  parameter bit IC_WINDOW = 1'b0
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  output logic                   rx_ready,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  input  wire logic              tx_ready,
  output logic                   irq_src,
  output logic                   rx_done,
  output logic                   tx_done,
  output logic [DATA_W-1:0]      rx_ptr,
  output logic [DATA_W-1:0]      tx_ptr
);
  import periph_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  stream_if rxq_in ();
  stream_if rxq_out ();

  logic [DATA_W-1:0] mode_r;
  logic [ST_W-1:0]   mask_r;
  logic [EN_W-1:0]   ensr_r;
  logic              endrx_r;
  logic              endtx_r;
  logic [7:0]        txbuf_r;
  tx_state_t         tx_state_r;
  tx_state_t         tx_state_nxt;
  logic [DATA_W-1:0] rx_ptr_w;
  logic [DATA_W-1:0] tx_ptr_w;
  logic [CNT_W-1:0]  rx_cnt_w;
  logic [CNT_W-1:0]  tx_cnt_w;
  logic              rx_act;
  logic              tx_act;

  // Word-only access and window decode
  wire [ADDR_W-1:0] waddr    = {paddr[ADDR_W-1:2], 2'b00};
  wire              in_win   = IC_WINDOW ? (paddr[ADDR_W-1:IC_ADDR_W] == '0) : 1'b1;
  wire              wr_en    = psel && penable && pwrite && in_win;
  wire              w_ctrl   = wr_en && (waddr == OFS_CTRL);
  wire              w_mode   = wr_en && (waddr == OFS_MODE);
  wire              w_ier    = wr_en && (waddr == OFS_IER);
  wire              w_idr    = wr_en && (waddr == OFS_IDR);
  wire              w_tx     = wr_en && (waddr == OFS_TX_DATA);
  wire              w_rxp    = wr_en && (waddr == OFS_RX_PTR);
  wire              w_rxc    = wr_en && (waddr == OFS_RX_CNT);
  wire              w_txp    = wr_en && (waddr == OFS_TX_PTR);
  wire              w_txc    = wr_en && (waddr == OFS_TX_CNT);
  wire              w_en     = wr_en && (waddr == OFS_EN);
  wire              w_dis    = wr_en && (waddr == OFS_DIS);
  wire              rd_en    = psel && !pwrite && in_win;
  wire              rd_rx    = rd_en && penable && (waddr == OFS_RX_DATA);
  wire              cmd_clr  = w_ctrl && pwdata[CTRL_RST_END];
  wire              cmd_fl   = w_ctrl && pwdata[CTRL_FLUSH];
  wire              loopback = mode_r[MODE_LOOP];

  // Receive channel consumes one queued byte per step while its count is non-zero
  wire              rx_take  = rxq_out.valid && (rx_act || rd_rx);
  wire              rx_xfer  = rxq_out.valid && rx_act && !rd_rx;
  wire              tx_load  = (tx_state_r == TX_IDLE) && (w_tx || tx_act) && ensr_r[1];
  wire              tx_fin   = (tx_state_r == TX_SEND) && (loopback ? rxq_in.ready : tx_ready);
  wire              tx_xfer  = tx_fin && tx_act;

  wire [ST_W-1:0]   status_w = {endtx_r, endrx_r, (tx_state_r == TX_IDLE), rxq_out.valid};

  // Far end only hands over a byte when it saw ready, so the queue takes the same handshake
  assign rxq_in.valid  = loopback ? (tx_state_r == TX_SEND) : (rx_valid && rx_ready);
  assign rxq_in.data   = loopback ? txbuf_r : rx_data;
  assign rxq_out.ready = rx_take;

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rxq (
    .clk   (clk),
    .rst_n (rst_n),
    .flush (cmd_fl),
    .wr    (rxq_in),
    .rd    (rxq_out)
  );

  xfer_channel u_rx_ch (
    .clk    (clk),
    .rst_n  (rst_n),
    .ptr_we (w_rxp),
    .cnt_we (w_rxc),
    .wdata  (pwdata),
    .done   (rx_xfer),
    .ptr    (rx_ptr_w),
    .cnt    (rx_cnt_w),
    .active (rx_act)
  );

  xfer_channel u_tx_ch (
    .clk    (clk),
    .rst_n  (rst_n),
    .ptr_we (w_txp),
    .cnt_we (w_txc),
    .wdata  (pwdata),
    .done   (tx_xfer),
    .ptr    (tx_ptr_w),
    .cnt    (tx_cnt_w),
    .active (tx_act)
  );

  always_comb begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      TX_IDLE: begin
        if (tx_load) tx_state_nxt = TX_SEND;
      end
      TX_SEND: begin
        if (tx_fin) tx_state_nxt = TX_IDLE;
      end
      default: tx_state_nxt = TX_IDLE;
    endcase
  end

  // Read mux; unmapped offsets and unused bits return zero
  logic [DATA_W-1:0] rdata_w;
  always_comb begin
    rdata_w = ZERO32;
    case (waddr)
      OFS_MODE:    rdata_w = mode_r;
      OFS_IMR:     rdata_w = {{(DATA_W-ST_W){1'b0}}, mask_r};
      OFS_STATUS:  rdata_w = {{(DATA_W-ST_W){1'b0}}, status_w};
      OFS_RX_DATA: rdata_w = {{(DATA_W-BYTE_W){1'b0}}, rxq_out.data};
      OFS_RX_PTR:  rdata_w = rx_ptr_w;
      OFS_RX_CNT:  rdata_w = {{(DATA_W-CNT_W){1'b0}}, rx_cnt_w};
      OFS_TX_PTR:  rdata_w = tx_ptr_w;
      OFS_TX_CNT:  rdata_w = {{(DATA_W-CNT_W){1'b0}}, tx_cnt_w};
      OFS_ENSR:    rdata_w = {{(DATA_W-EN_W){1'b0}}, ensr_r};
      default:     rdata_w = ZERO32;
    endcase
  end

  // End flags track the count hitting zero; the set wins over a simultaneous clear
  wire rx_end_ev = rx_xfer && (rx_cnt_w == CNT_STEP);
  wire tx_end_ev = tx_xfer && (tx_cnt_w == CNT_STEP);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r  <= MODE_RST;
      mask_r  <= '0;
      ensr_r  <= '0;
      endrx_r <= 1'b0;
      endtx_r <= 1'b0;
    end else begin
      if (w_mode) mode_r <= {{(DATA_W-1){1'b0}}, pwdata[MODE_LOOP]};
      mask_r  <= (mask_r | ({ST_W{w_ier}} & pwdata[ST_W-1:0]))
                 & ~({ST_W{w_idr && !w_ier}} & pwdata[ST_W-1:0]);
      ensr_r  <= (ensr_r & ~({EN_W{w_dis}} & pwdata[EN_W-1:0]))
                 | ({EN_W{w_en}} & pwdata[EN_W-1:0]);
      endrx_r <= rx_end_ev | (endrx_r & ~cmd_clr);
      endtx_r <= tx_end_ev | (endtx_r & ~cmd_clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= TX_IDLE;
      txbuf_r    <= '0;
      tx_valid   <= 1'b0;
      tx_data    <= '0;
    end else begin
      tx_state_r <= tx_state_nxt;
      if (tx_load) txbuf_r <= w_tx ? pwdata[BYTE_W-1:0] : tx_ptr_w[BYTE_W-1:0];
      tx_valid   <= (tx_state_nxt == TX_SEND) && !loopback;
      if (tx_load) tx_data <= w_tx ? pwdata[BYTE_W-1:0] : tx_ptr_w[BYTE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata   <= ZERO32;
      irq_src  <= 1'b0;
      rx_ready <= 1'b0;
      rx_done  <= 1'b0;
      tx_done  <= 1'b0;
      rx_ptr   <= ZERO32;
      tx_ptr   <= ZERO32;
    end else begin
      prdata   <= rd_en ? rdata_w : ZERO32;
      irq_src  <= |(status_w & mask_r);
      // Ready is a cycle late, so drop it after a take in case that take filled the queue
      rx_ready <= rxq_in.ready && ensr_r[0] && !loopback && !(rx_valid && rx_ready);
      rx_done  <= endrx_r;
      tx_done  <= endtx_r;
      rx_ptr   <= rx_ptr_w;
      tx_ptr   <= tx_ptr_w;
    end
  end
endmodule : periph_regs

/* src/periph_pkg.sv */
// Package holding the register map, field layout and reset values of the peripheral block
package periph_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 14;
  localparam int          IC_ADDR_W       = 12;
  localparam int          CNT_W           = 16;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          BYTE_W          = 8;
  localparam int          CH_NUM          = 4;
  localparam logic [13:0] OFS_CTRL        = 14'h0000;
  localparam logic [13:0] OFS_MODE        = 14'h0004;
  localparam logic [13:0] OFS_IER         = 14'h0008;
  localparam logic [13:0] OFS_IDR         = 14'h000C;
  localparam logic [13:0] OFS_IMR         = 14'h0010;
  localparam logic [13:0] OFS_STATUS      = 14'h0014;
  localparam logic [13:0] OFS_TX_DATA     = 14'h0018;
  localparam logic [13:0] OFS_RX_DATA     = 14'h001C;
  localparam logic [13:0] OFS_RX_PTR      = 14'h0030;
  localparam logic [13:0] OFS_RX_CNT      = 14'h0034;
  localparam logic [13:0] OFS_TX_PTR      = 14'h0038;
  localparam logic [13:0] OFS_TX_CNT      = 14'h003C;
  localparam logic [13:0] OFS_EN          = 14'h0040;
  localparam logic [13:0] OFS_DIS         = 14'h0044;
  localparam logic [13:0] OFS_ENSR        = 14'h0048;
  localparam logic [31:0] MODE_RST        = 32'h0000_0000;
  localparam logic [31:0] ZERO32          = 32'h0000_0000;
  localparam logic [15:0] ZERO16          = 16'h0000;
  localparam logic [31:0] PTR_STEP        = 32'h0000_0001;
  localparam logic [15:0] CNT_STEP        = 16'h0001;
  localparam int          ST_W            = 4;
  localparam int          ST_RXRDY        = 0;
  localparam int          ST_TXRDY        = 1;
  localparam int          ST_ENDRX        = 2;
  localparam int          ST_ENDTX        = 3;
  localparam int          CTRL_RST_END    = 0;
  localparam int          CTRL_FLUSH      = 1;
  localparam int          MODE_LOOP       = 0;
  localparam int          EN_W            = 2;
endpackage : periph_pkg

/* src/stream_if.sv */
// Interface carrying one valid/ready byte stream between the block's modules
`timescale 1ns/1ps
interface stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

/* src/byte_fifo.sv */
// Small parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic flush,
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = wr.valid && wr.ready;
  wire              pop  = rd.valid && rd.ready;
  assign wr.ready = (cnt_r != DEPTH[AW:0]);
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

/* src/xfer_channel.sv */
// One transfer-engine channel: address pointer, transfer count and active flag
`timescale 1ns/1ps
module xfer_channel
  import periph_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ptr_we,
  input  wire logic              cnt_we,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              done,
  output logic [DATA_W-1:0]      ptr,
  output logic [CNT_W-1:0]       cnt,
  output logic                   active
);
  assign active = (cnt != ZERO16);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= ZERO32;
      cnt <= ZERO16;
    end else begin
      if (ptr_we) ptr <= wdata;
      else if (done && active) ptr <= ptr + PTR_STEP;
      if (cnt_we) cnt <= wdata[CNT_W-1:0];
      else if (done && active) cnt <= cnt - CNT_STEP;
    end
  end
endmodule : xfer_channel

/* testbench/periph_regs_assertions.sv */
// Port-level assertions for the peripheral register bank
`timescale 1ns/1ps
module periph_regs_assertions
  import periph_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        irq_src,
  input wire logic        rx_done,
  input wire logic        tx_done,
  input wire logic [31:0] rx_ptr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire        rd  = psel && !pwrite;
  wire        wr  = psel && penable && pwrite;
  wire [11:0] wa  = paddr[13:2];
  wire        pw  = wr && wa == OFS_RX_PTR[13:2];
  wire        set = wr && wa == OFS_IER[13:2];
  wire        clr = wr && wa == OFS_IDR[13:2];
  logic [3:0] msk_r;
  logic [1:0] pw_r;
  wire  [3:0] msk_nxt = set ? msk_r | pwdata[3:0] : clr ? msk_r & ~pwdata[3:0] : msk_r;
  // Pointer history starts busy so a reset-time jump is not taken for a step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= 4'h0;
      pw_r  <= 2'h3;
    end else begin
      msk_r <= msk_nxt;
      pw_r  <= {pw_r[0], pw};
    end
  end
  a_ctrl_write_only: assert property (rd && wa == OFS_CTRL[13:2] |=> prdata == ZERO32)
    else $error("control register read back non-zero");
  a_mode_unused_zero: assert property (rd && wa == OFS_MODE[13:2] |=> prdata[31:1] == 31'h0)
    else $error("mode unused bits non-zero");
  a_cnt_width: assert property (rd && wa == OFS_RX_CNT[13:2] |=> prdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  a_mask_read: assert property (rd && wa == OFS_IMR[13:2] |=> prdata == {28'h0, msk_r})
    else $error("mask register wrong");
  a_irq_masked: assert property (msk_r == 4'h0 |=> !irq_src)
    else $error("interrupt with all masked");
  a_irq_end_rx: assert property (msk_r[ST_ENDRX] && rx_done |-> ##[0:2] irq_src)
    else $error("unmasked end flag gave no interrupt");
  a_end_clear: assert property (wr && wa == OFS_CTRL[13:2] && pwdata[CTRL_RST_END]
    |-> ##[1:2] (!rx_done && !tx_done))
    else $error("end flags not cleared");
  a_ptr_step: assert property (!pw && pw_r == 2'h0 && $changed(rx_ptr)
    |-> rx_ptr == $past(rx_ptr) + PTR_STEP)
    else $error("pointer moved by other than one step");
endmodule : periph_regs_assertions

bind periph_regs periph_regs_assertions chk_i (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .irq_src(irq_src), .rx_done(rx_done), .tx_done(tx_done), .rx_ptr(rx_ptr));

/* testbench/stream_far_end.sv */
// Far end of both byte streams: feeds incoming bytes, collects outgoing ones
`timescale 1ns/1ps
module stream_far_end (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] to_send[$];
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5A;
    tx_ready = 1'b0;
  end
  // Offer holds until taken; idle data toggles so stale bytes never match
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (rx_valid && rx_ready) void'(to_send.pop_front());
    #1;
    tx_ready = rst_n && !stall && ($urandom_range(3) != 0);
    rx_valid = rst_n && (to_send.size() != 0);
    rx_data = rx_valid ? to_send[0] : ~rx_data;
  end
endmodule : stream_far_end

/* testbench/testbench.sv */
// Self-checking bench for the peripheral register bank
`timescale 1ns/1ps
module testbench;
  import periph_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n, psel, penable, pwrite, stall, rx_valid, rx_ready;
  logic              tx_valid, tx_ready, irq_src, rx_done, tx_done;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rx_ptr, tx_ptr, d, p;
  logic [7:0]        rx_data, tx_data;
  logic [7:0]        b[4];
  logic [3:0]        msk, ens;
  int                n_fail = 0, n_tests = 0, cyc = 0, n;

  always #50 clk = ~clk;

  periph_regs uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .irq_src(irq_src), .rx_done(rx_done), .tx_done(tx_done), .rx_ptr(rx_ptr), .tx_ptr(tx_ptr));
  stream_far_end far (.clk(clk), .rst_n(rst_n), .stall(stall), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  function automatic logic [3:0] upd(input logic [3:0] o, input logic [3:0] v, input bit s);
    return s ? (o | v) : (o & ~v);
  endfunction : upd

  task automatic close_out;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // Setup then access phase; read data is taken at the access edge
  task automatic acc(input bit w, input logic [13:0] a, input logic [31:0] v);
    @(posedge clk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = v;
    @(posedge clk);
    #1;
    penable = 1'b1;
    @(posedge clk);
    #1;
    d = prdata;
    psel = 1'b0;
    penable = 1'b0;
  endtask : acc

  task automatic rdc(input logic [13:0] a, input logic [31:0] exp);
    acc(1'b0, a, ZERO32);
    chk(d, exp);
  endtask : rdc

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, stall, msk, ens} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    n = $urandom(25);
    rdc(OFS_MODE, MODE_RST);
    rdc(OFS_IMR, ZERO32);
    rdc(OFS_CTRL, ZERO32);
    for (int i = 0; i < 8; i++) begin
      p = $urandom;
      acc(1'b1, i[0] ? OFS_IDR : OFS_IER, {28'h0, p[3:0]});
      msk = upd(msk, p[3:0], !i[0]);
      rdc(OFS_IMR, {28'h0, msk});
      acc(1'b1, p[4] ? OFS_DIS : OFS_EN, {30'h0, p[6:5]});
      ens = upd(ens, {2'h0, p[6:5]}, !p[4]);
      rdc(OFS_ENSR, {28'h0, ens});
      acc(1'b1, OFS_MODE, {31'h0, p[7]});
      rdc(OFS_MODE | 14'h0003, {31'h0, p[7]});
      acc(1'b1, {2'h1, p[11:2], 2'h0}, p);
      rdc({2'h1, p[11:2], 2'h0}, ZERO32);
    end
    acc(1'b1, OFS_MODE, ZERO32);
    p = 32'h0000_0001 << ST_TXRDY;
    rdc(OFS_STATUS, p);
    acc(1'b1, OFS_STATUS, 32'h0000_000F);
    rdc(OFS_STATUS, p);
    acc(1'b1, OFS_IDR, 32'h0000_000F);
    acc(1'b1, OFS_EN, 32'h0000_0003);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      if (i < 4) b[i] = d[7:0];
      far.to_send.push_back(d[7:0]);
    end
    repeat (20) @(posedge clk);
    chk(32'(far.to_send.size()), 32'h0000_0002);
    for (int i = 0; i < 4; i++) rdc(OFS_RX_DATA, {24'h0, b[i]});
    repeat (10) @(posedge clk);
    acc(1'b1, OFS_CTRL, 32'h0000_0002);
    acc(1'b0, OFS_STATUS, ZERO32);
    chk({31'h0, d[ST_RXRDY]}, ZERO32);
    p = $urandom;
    n = $urandom_range(5, 2);
    acc(1'b1, OFS_IER, 32'h0000_0001 << ST_ENDRX);
    acc(1'b1, OFS_RX_PTR, p);
    acc(1'b1, OFS_RX_CNT, 32'(n));
    repeat (n) far.to_send.push_back(8'($urandom));
    for (int i = 0; i < 300 && rx_done !== 1'b1; i++) @(posedge clk);
    rdc(OFS_RX_CNT, ZERO32);
    rdc(OFS_RX_PTR, p + n);
    chk(rx_ptr, p + n);
    acc(1'b0, OFS_STATUS, ZERO32);
    chk({31'h0, d[ST_ENDRX]}, 32'h0000_0001);
    chk({31'h0, irq_src}, 32'h0000_0001);
    acc(1'b1, OFS_IDR, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_src}, ZERO32);
    acc(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_done}, ZERO32);
    stall = 1'b1;
    p = $urandom;
    acc(1'b1, OFS_TX_PTR, p);
    acc(1'b1, OFS_TX_CNT, 32'h0000_0003);
    acc(1'b1, OFS_EN, 32'h0000_0002);
    repeat (8) @(posedge clk);
    stall = 1'b0;
    for (int i = 0; i < 300 && tx_done !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(32'(far.got.size()), 32'h0000_0003);
    for (int i = 0; i < 3; i++) chk({24'h0, far.got[i]}, {24'h0, 8'(p + i)});
    chk(tx_ptr, p + 3);
    acc(1'b1, OFS_MODE, 32'h0000_0001);
    p = $urandom;
    acc(1'b1, OFS_TX_DATA, {24'h0, p[7:0]});
    rdc(OFS_RX_DATA, {24'h0, p[7:0]});
    chk(32'(far.got.size()), 32'h0000_0003);
    close_out();
  end
endmodule : testbench
